// ==== include/bofs_map.svh ====
// Constants for the brownout and thermal fault supervisor
`ifndef BOFS_MAP_SVH
`define BOFS_MAP_SVH
// ==========================================
// Clock and timing
`define BOFS_CLK_HZ            10000000
`define BOFS_LOSS_DELAY_US     30000
`define BOFS_RETURN_DELAY_US   250
`define BOFS_OFF_TIME_MS       2000
`define BOFS_JITTER_HZ         10000
`define BOFS_LOSS_CYC   ((`BOFS_CLK_HZ / 1000000) * `BOFS_LOSS_DELAY_US)
`define BOFS_RETURN_CYC ((`BOFS_CLK_HZ / 1000000) * `BOFS_RETURN_DELAY_US)
`define BOFS_OFF_CYC    ((`BOFS_CLK_HZ / 1000) * `BOFS_OFF_TIME_MS)
`define BOFS_JIT_HALF_CYC (`BOFS_CLK_HZ / (2 * `BOFS_JITTER_HZ))
// Default modulation depth of the peak current, percent
`define BOFS_JITTER_DEPTH_PCT  5
// Filter counter width
`define BOFS_FCNT_W            20
`endif

// ==== include/bofs_pkg.sv ====
// Types for the brownout and thermal fault supervisor
package bofs_pkg;
   typedef enum logic [4:0] {
      BOFS_CHECK   = 5'h01,
      BOFS_WAIT_IN = 5'h02,
      BOFS_RUN     = 5'h04,
      BOFS_LINE_OFF= 5'h08,
      BOFS_HOT_OFF = 5'h10
   } bofs_state_t;
endpackage

// ==== design/bofs_filter.sv ====
// Up/down delay filter counter
`timescale 1ns/1ps
module bofs_filter #(
   parameter int unsigned LIMIT = 16
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic clr,
   input  wire logic cond,
   output logic      fire
);
   logic [19:0] cnt_q;
   logic [19:0] cnt_d;
   localparam logic [19:0] LIM = 20'(LIMIT);

   // R8: count up or down
   assign cnt_d = clr ? 20'h00000 :
                  cond ? ((cnt_q == LIM) ? cnt_q : cnt_q + 20'h00001) :
                  ((cnt_q == 20'h00000) ? cnt_q : cnt_q - 20'h00001);
   assign fire  = (cnt_q == LIM);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 20'h00000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   AST_FILT_DOWN: assert property (@(posedge clk) disable iff (!rstn)
      (!clr && !cond && cnt_q != 20'h00000) |=> cnt_q == $past(cnt_q) - 20'h00001) // R8
      else $error("filter did not count down");
   AST_FILT_UP: assert property (@(posedge clk) disable iff (!rstn)
      (!clr && cond && !fire) |=> cnt_q == $past(cnt_q) + 20'h00001) // R8
      else $error("filter did not count up");
endmodule

// ==== design/bofs_supervisor.sv ====
// Brownout, thermal shutdown and jitter supervisor
`timescale 1ns/1ps
// What this block does
// R1: During supply charge-up, source test current from line sense pin and observe it.
// R2: Line sense below disable level at check: latch monitor off, start freely.
// R3: Above disable level: latch monitor on, switch only after turn-on level.
// R4: Line below turn-off level beyond loss delay stops switching.
// R5: While stopped by line loss, periodically enable start-up current source.
// R6: After line loss, line above turn-on level beyond return delay resumes.
// R7: Both delays use up/down counters to reject disturbances.
// R8: Counters rise when condition holds, fall otherwise, fire at limit.
// R9: Emit 10 kHz half-duty square wave for 5 percent peak modulation.
// R10: Overtemp stops switching for the off time, then restarts at supply turn-on.
// R11: During overtemp off, keep cycling supply and enter low-consumption fault.
// R12: Synchronise all comparator inputs before use.
`include "bofs_map.svh"
module bofs_supervisor #(
   parameter int unsigned LOSS_CYC   = `BOFS_LOSS_CYC,
   parameter int unsigned RETURN_CYC = `BOFS_RETURN_CYC,
   parameter int unsigned OFF_CYC    = `BOFS_OFF_CYC
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic line_above_disable,
   input  wire logic line_above_turn_on,
   input  wire logic line_above_turn_off,
   input  wire logic overtemp,
   input  wire logic supply_at_turn_on,
   input  wire logic supply_at_restart,
   output logic      switch_en,
   output logic      startup_src_en,
   output logic      line_sense_test_current,
   output logic      fault_low_power,
   output logic      line_monitor_on,
   output logic      jitter_out
);
   // ==========================================
   // Input synchronisers
   logic [5:0] raw;
   logic [5:0] s1_q;
   logic [5:0] s2_q;
   assign raw = {supply_at_restart, supply_at_turn_on, overtemp,
                 line_above_turn_off, line_above_turn_on, line_above_disable};
   // R12: two-stage sync
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   wire dis_s  = s2_q[0];
   wire on_s   = s2_q[1];
   wire off_s  = s2_q[2];
   wire hot_s  = s2_q[3];
   wire von_s  = s2_q[4];
   wire vrst_s = s2_q[5];

   // ==========================================
   // State and latched monitor decision
   bofs_pkg::bofs_state_t st_q;
   bofs_pkg::bofs_state_t st_d;
   logic mon_q;
   logic mon_d;
   logic src_q;
   logic src_d;
   logic [24:0] off_cnt_q;
   logic [24:0] off_cnt_d;
   logic loss_fire;
   logic ret_fire;
   logic [9:0] jit_cnt_q;
   logic jit_q;

   wire in_run   = (st_q == bofs_pkg::BOFS_RUN);
   wire in_loff  = (st_q == bofs_pkg::BOFS_LINE_OFF);
   wire in_hot   = (st_q == bofs_pkg::BOFS_HOT_OFF);
   wire off_done = (off_cnt_q == 25'(OFF_CYC));

   // R7: line loss filter
   bofs_filter #(.LIMIT(LOSS_CYC)) u_loss (
      .clk  (clk),
      .rstn (rstn),
      .clr  (!in_run || !mon_q),
      .cond (!off_s),
      .fire (loss_fire)
   );
   // R7: line return filter
   bofs_filter #(.LIMIT(RETURN_CYC)) u_ret (
      .clk  (clk),
      .rstn (rstn),
      .clr  (!in_loff),
      .cond (on_s),
      .fire (ret_fire)
   );

   always_comb begin
      st_d  = st_q;
      mon_d = mon_q;
      case (st_q)
         bofs_pkg::BOFS_CHECK: begin
            // R2: decision taken at supply turn-on
            if (von_s) begin
               mon_d = dis_s;
               if (hot_s) begin
                  st_d = bofs_pkg::BOFS_HOT_OFF;
               end else if (dis_s) begin
                  st_d = bofs_pkg::BOFS_WAIT_IN;
               end else begin
                  st_d = bofs_pkg::BOFS_RUN;
               end
            end
         end
         bofs_pkg::BOFS_WAIT_IN: begin
            // R3: wait for line turn-on level
            if (hot_s) begin
               st_d = bofs_pkg::BOFS_HOT_OFF;
            end else if (on_s) begin
               st_d = bofs_pkg::BOFS_RUN;
            end
         end
         bofs_pkg::BOFS_RUN: begin
            // R10: overtemp takes priority
            if (hot_s) begin
               st_d = bofs_pkg::BOFS_HOT_OFF;
            end else if (loss_fire) begin
               // R4: line loss stop
               st_d = bofs_pkg::BOFS_LINE_OFF;
            end
         end
         bofs_pkg::BOFS_LINE_OFF: begin
            if (hot_s) begin
               st_d = bofs_pkg::BOFS_HOT_OFF;
            end else if (ret_fire) begin
               // R6: line return resume
               st_d = bofs_pkg::BOFS_RUN;
            end
         end
         bofs_pkg::BOFS_HOT_OFF: begin
            // R10: restart after off time at supply turn-on
            if (off_done && von_s && !hot_s) begin
               st_d = (mon_q && !on_s) ? bofs_pkg::BOFS_WAIT_IN : bofs_pkg::BOFS_RUN;
            end
         end
         default: begin
            st_d = bofs_pkg::BOFS_CHECK;
         end
      endcase
   end

   // ==========================================
   // Off timer
   assign off_cnt_d = !in_hot ? 25'h0000000 :
                      (off_done ? off_cnt_q : off_cnt_q + 25'h0000001);

   // ==========================================
   // States after the check in which switching is held off
   function automatic logic is_stopped(input bofs_pkg::bofs_state_t s);
      is_stopped = (s == bofs_pkg::BOFS_WAIT_IN) ||
                   (s == bofs_pkg::BOFS_LINE_OFF) ||
                   (s == bofs_pkg::BOFS_HOT_OFF);
   endfunction

   // R5: supply recycling hysteresis for start-up source
   wire stopped = is_stopped(st_q);
   assign src_d = (st_q == bofs_pkg::BOFS_CHECK) ? 1'b1 :
                  !stopped ? 1'b0 :
                  von_s ? 1'b0 :
                  vrst_s ? 1'b1 : src_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q      <= bofs_pkg::BOFS_CHECK;
         mon_q     <= 1'b0;
         src_q     <= 1'b1;
         off_cnt_q <= 25'h0000000;
      end else begin
         st_q      <= st_d;
         mon_q     <= mon_d;
         src_q     <= src_d;
         off_cnt_q <= off_cnt_d;
      end
   end

   // ==========================================
   // R9: jitter square wave, half period count
   localparam logic [9:0] JIT_HALF = 10'(`BOFS_JIT_HALF_CYC);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         jit_cnt_q <= 10'h000;
         jit_q     <= 1'b0;
      end else if (jit_cnt_q == JIT_HALF - 10'h001) begin
         jit_cnt_q <= 10'h000;
         jit_q     <= ~jit_q;
      end else begin
         jit_cnt_q <= jit_cnt_q + 10'h001;
      end
   end

   // ==========================================
   // Outputs
   // R1: test current only during the check
   assign line_sense_test_current = (st_q == bofs_pkg::BOFS_CHECK);
   assign switch_en       = in_run;
   assign startup_src_en  = src_q;
   // R11: reduced consumption in thermal fault
   assign fault_low_power = in_hot;
   assign line_monitor_on = mon_q;
   assign jitter_out      = jit_q && in_run;

   // ==========================================
   // Checks
   AST_LOSS_STOP: assert property (@(posedge clk) disable iff (!rstn)
      (in_run && loss_fire && !hot_s) |=> in_loff) // R4
      else $error("line loss did not stop switching");
   AST_RETURN: assert property (@(posedge clk) disable iff (!rstn)
      (in_loff && ret_fire && !hot_s) |=> in_run) // R6
      else $error("line return did not resume");
   AST_HOT_STOP: assert property (@(posedge clk) disable iff (!rstn)
      (hot_s && !in_hot && st_q != bofs_pkg::BOFS_CHECK) |=> in_hot && !switch_en) // R10
      else $error("overtemp did not stop switching");
   AST_HOT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      (in_hot && !off_done) |=> in_hot) // R10
      else $error("left thermal off early");
   AST_FAULT_LP: assert property (@(posedge clk) disable iff (!rstn)
      in_hot |-> fault_low_power && !switch_en) // R11
      else $error("fault state not low power");
   AST_SRC_ON: assert property (@(posedge clk) disable iff (!rstn)
      (in_loff && vrst_s && !von_s) |=> startup_src_en) // R5
      else $error("start-up source not enabled");
   AST_MON_HELD: assert property (@(posedge clk) disable iff (!rstn)
      (st_q != bofs_pkg::BOFS_CHECK) |=> mon_q == $past(mon_q)) // R2
      else $error("monitor decision changed");
   AST_NO_SW_LOW: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == bofs_pkg::BOFS_WAIT_IN && !on_s) |=> !switch_en) // R3
      else $error("switched below turn-on level");
   AST_TEST_I: assert property (@(posedge clk) disable iff (!rstn)
      line_sense_test_current |-> !switch_en) // R1
      else $error("test current while switching");
   AST_JIT: assert property (@(posedge clk) disable iff (!rstn)
      (jit_cnt_q == JIT_HALF - 10'h001) |=> jit_q != $past(jit_q)) // R9
      else $error("jitter did not toggle");
   AST_SYNC: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |-> ##2 s2_q == $past(raw, 2)) // R12
      else $error("sync latency wrong");

   // ==========================================
   // Transition checks
   wire in_wait = (st_q == bofs_pkg::BOFS_WAIT_IN);
   AST_MON_LATCH: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == bofs_pkg::BOFS_CHECK && von_s) |=> mon_q == $past(dis_s)) // R3
      else $error("monitor decision not latched from line sense");
   AST_CHECK_WAIT: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == bofs_pkg::BOFS_CHECK && !von_s) |=> st_q == bofs_pkg::BOFS_CHECK) // R1
      else $error("left power-up check before supply turn-on");
   AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      (in_wait && !on_s && !hot_s) |=> in_wait) // R3
      else $error("left line wait below turn-on level");
   AST_LOSS_NEEDS_MON: assert property (@(posedge clk) disable iff (!rstn)
      (in_run && !mon_q) |=> !in_loff) // R2
      else $error("line loss acted with monitor disabled");
   AST_LOSS_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      (in_run && !loss_fire && !hot_s) |=> in_run) // R7
      else $error("switching stopped before loss delay");
   AST_RET_HOLD: assert property (@(posedge clk) disable iff (!rstn)
      (in_loff && !ret_fire && !hot_s) |=> in_loff) // R7
      else $error("switching resumed before return delay");
   AST_SRC_OFF: assert property (@(posedge clk) disable iff (!rstn)
      (is_stopped(st_q) && von_s) |=> !startup_src_en) // R5
      else $error("start-up source left on at supply turn-on");
   AST_SRC_RUN: assert property (@(posedge clk) disable iff (!rstn)
      in_run |=> !startup_src_en) // R5
      else $error("start-up source on while switching");
   AST_HOT_EXIT: assert property (@(posedge clk) disable iff (!rstn)
      (in_hot && off_done && von_s && !hot_s) |=> !in_hot) // R10
      else $error("no restart after thermal off time");

   // ==========================================
   // Independent count of the thermal off period
   logic [24:0] hot_len_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hot_len_q <= 25'h0000000;
      end else if (!in_hot) begin
         hot_len_q <= 25'h0000000;
      end else if (hot_len_q != 25'h1ffffff) begin
         hot_len_q <= hot_len_q + 25'h0000001;
      end
   end
   // R10: off time respected
   AST_HOT_LEN: assert property (@(posedge clk) disable iff (!rstn)
      (in_hot ##1 !in_hot) |-> $past(hot_len_q) >= 25'(OFF_CYC)) // R10
      else $error("thermal off period too short");

   COV_LOSS: cover property (@(posedge clk) disable iff (!rstn) in_run ##1 in_loff);
   COV_RET: cover property (@(posedge clk) disable iff (!rstn) in_loff ##1 in_run);
   COV_HOT: cover property (@(posedge clk) disable iff (!rstn) in_hot ##1 !in_hot);
   COV_DIS: cover property (@(posedge clk) disable iff (!rstn)
      (st_q == bofs_pkg::BOFS_CHECK) ##1 (in_run && !mon_q));
   COV_WAIT: cover property (@(posedge clk) disable iff (!rstn)
      in_wait ##1 in_run);
endmodule

// ==== verif/bofs_partner.sv ====
// Comparator and supply capacitor model around the supervisor
`timescale 1ns/1ps
module bofs_partner (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [15:0] line_mv,
   input  wire logic        hot,
   input  wire logic        switch_en,
   input  wire logic        startup_src_en,
   input  wire logic        fault_low_power,
   output logic             line_above_disable,
   output logic             line_above_turn_on,
   output logic             line_above_turn_off,
   output logic             overtemp,
   output logic             supply_at_turn_on,
   output logic             supply_at_restart
);
   int vdd = 0;
   int tick = 0;
   // ==========================================
   // Comparators
   assign line_above_disable  = line_mv > 16'd100;
   assign line_above_turn_on  = line_mv > 16'd500;
   assign line_above_turn_off = line_mv > 16'd400;
   assign overtemp            = hot;
   assign supply_at_turn_on   = vdd >= 40;
   assign supply_at_restart   = vdd <= 10;
   // ==========================================
   // Supply: charged by the source, drained while idle, slower in fault
   always @(negedge clk) begin
      tick <= tick + 1;
      if (!rstn)
         vdd <= 0;
      else if (startup_src_en && vdd < 40)
         vdd <= vdd + 1;
      else if (!startup_src_en && !switch_en && vdd > 0 && (!fault_low_power || tick % 4 == 0))
         vdd <= vdd - 1;
   end
endmodule

// ==== verif/brownout_thermal_fault_supervisor_bench.sv ====
// Self-checking bench for the brownout and thermal fault supervisor
`timescale 1ns/1ps
`include "bofs_map.svh"
module brownout_thermal_fault_supervisor_bench;
   localparam int LOSS = 20;
   localparam int RET  = 10;
   localparam int OFF  = 50;
   logic        clk     = 1'b0;
   logic        rstn    = 1'b0;
   logic        hot     = 1'b0;
   logic [15:0] line_mv = 16'h0000;
   logic        l_dis, l_on, l_off, ot, s_on, s_rst;
   logic        sw, src, tcur, flp, mon, jit;
   int          n_fail     = 0;
   int          n_compared = 0;
   int          n;
   always #50 clk = ~clk;
   bofs_supervisor #(.LOSS_CYC(LOSS), .RETURN_CYC(RET), .OFF_CYC(OFF)) u_dut (
      .clk(clk), .rstn(rstn), .line_above_disable(l_dis), .line_above_turn_on(l_on),
      .line_above_turn_off(l_off), .overtemp(ot), .supply_at_turn_on(s_on),
      .supply_at_restart(s_rst), .switch_en(sw), .startup_src_en(src),
      .line_sense_test_current(tcur), .fault_low_power(flp), .line_monitor_on(mon),
      .jitter_out(jit));
   bofs_partner u_far (
      .clk(clk), .rstn(rstn), .line_mv(line_mv), .hot(hot), .switch_en(sw),
      .startup_src_en(src), .fault_low_power(flp), .line_above_disable(l_dis),
      .line_above_turn_on(l_on), .line_above_turn_off(l_off), .overtemp(ot),
      .supply_at_turn_on(s_on), .supply_at_restart(s_rst));
   // ==========================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_sw(input logic v, input int lim);
      n = 0;
      while (sw !== v && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic power_up(input logic [15:0] mv);
      @(negedge clk);
      rstn = 1'b0;
      line_mv = mv;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
   endtask
   task automatic test_done;
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_no_monitor;
      power_up(16'd50);
      @(negedge clk);
      check(tcur, 1'b1);
      wait_sw(1'b1, 200);
      check(sw, 1'b1);
      check(mon, 1'b0);
      repeat (2) @(negedge clk);
      check(tcur, 1'b0);
      line_mv = 16'd300;
      repeat (3 * LOSS) @(negedge clk);
      check(sw, 1'b1);
   endtask
   task automatic t_monitor;
      power_up(16'd450);
      check(tcur, 1'b1);
      check(sw, 1'b0);
      repeat (100) @(negedge clk);
      check(mon, 1'b1);
      check(sw, 1'b0);
      line_mv = 16'd600;
      wait_sw(1'b1, RET + 20);
      check(sw, 1'b1);
   endtask
   task automatic t_brown;
      int   edges;
      logic src_prev;
      edges = 0;
      repeat (4) begin
         line_mv = 16'd300;
         repeat (LOSS / 2) @(negedge clk);
         line_mv = 16'd600;
         repeat (LOSS / 2) @(negedge clk);
      end
      check(sw, 1'b1);
      line_mv = 16'd300;
      wait_sw(1'b0, LOSS + 10);
      check(n >= LOSS, 1'b1);
      check(sw, 1'b0);
      src_prev = src;
      repeat (200) begin
         @(negedge clk);
         if (src === 1'b1 && src_prev === 1'b0)
            edges++;
         src_prev = src;
      end
      check(edges >= 2, 1'b1);
      line_mv = 16'd600;
      wait_sw(1'b1, RET + 10);
      check(n >= RET, 1'b1);
      check(sw, 1'b1);
   endtask
   task automatic t_jitter;
      n = 0;
      while (jit !== 1'b0 && n < 1200) begin
         @(negedge clk);
         n++;
      end
      wait_sw(1'b1, 1);
      while (jit !== 1'b1 && n < 2400) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (jit === 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      check(n, `BOFS_JIT_HALF_CYC);
      n = 0;
      while (jit === 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      check(n, `BOFS_JIT_HALF_CYC);
   endtask
   task automatic t_hot;
      hot = 1'b1;
      wait_sw(1'b0, 10);
      check(sw, 1'b0);
      check(flp, 1'b1);
      check(jit, 1'b0);
      repeat (5) @(negedge clk);
      hot = 1'b0;
      wait_sw(1'b1, OFF + 300);
      check(n + 5 >= OFF, 1'b1);
      check(sw, 1'b1);
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      t_no_monitor();
      t_monitor();
      t_brown();
      t_jitter();
      t_hot();
      test_done();
   end
   initial begin
      #1000000;
      n_fail++;
      test_done();
   end
endmodule
